// ==== gen_reg_bank.v ====
// Four 16-bit general registers with registered read data.
// Assumes one writer port and one capture port, priority to capture.
`include "timer_map.vh"
`default_nettype none

module gen_reg_bank (
    // Clock and reset
    input wire pclk,
    input wire presetn,
    // Write port
    input wire wr_en,
    input wire [1:0] wr_sel,
    input wire [15:0] wr_data,
    // Per-entry load strobes and data
    input wire [3:0] ld_en,
    input wire [63:0] ld_data,
    // Outputs and read select
    output wire [63:0] q_all,
    input wire [1:0] rd_sel,
    output reg [15:0] rd_data
);

    // One register per entry, each with a single driving process
    genvar i;
    generate
        for (i = 0; i < 4; i = i + 1) begin : g_ent
            reg [15:0] ent_r;
            always @(posedge pclk or negedge presetn) begin
                if (!presetn) begin
                    ent_r <= `GR_RESET;
                end else if (ld_en[i]) begin
                    ent_r <= ld_data[16*i +: 16];
                end else if (wr_en && wr_sel == i) begin
                    ent_r <= wr_data;
                end
            end
            assign q_all[16*i +: 16] = ent_r;
        end
    endgenerate

    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            rd_data <= 16'h0000;
        end else begin
            rd_data <= q_all[16*rd_sel +: 16];
        end
    end

endmodule

`default_nettype wire

// ==== pin_model.sv ====
// Far-side pin model: event input, subclock and capture pins.
// Assumes the bench calls its task from the main sequence.
`default_nettype none
module pin_model (
    // Pins toward the timer
    output var logic external_event_in,
    output var logic subclock_tick,
    output var logic [3:0] timer_pin_in
);
    timeunit 1ns;
    timeprecision 1ps;
    initial begin
        external_event_in = 1'b0;
        subclock_tick = 1'b0;
        timer_pin_in = 4'h0;
    end
    task automatic pulse(input bit sub, input int n);
        repeat (n) begin
            #97;
            if (sub) subclock_tick = 1'b1;
            else external_event_in = 1'b1;
            #113;
            subclock_tick = 1'b0;
            external_event_in = 1'b0;
        end
    endtask
endmodule
`default_nettype wire

// ==== timer_map.vh ====
// Register map and field positions of the compare/capture timer.
// Assumes APB byte addressing with one aligned 32-bit word per register.
`ifndef TIMER_MAP_VH
`define TIMER_MAP_VH

`define OFS_MODE 8'h00
`define OFS_CTRL 8'h04
`define OFS_COUNT 8'h08
`define OFS_GRA 8'h0C
`define OFS_GRB 8'h10
`define OFS_GRC 8'h14
`define OFS_GRD 8'h18
`define OFS_IOSEL 8'h1C
`define OFS_LOWPWR 8'h20

`define MODE_RUN 7
`define MODE_BUF_B 5
`define MODE_BUF_A 4
`define MODE_PWM_D 2
`define MODE_PWM_C 1
`define MODE_PWM_B 0
`define MODE_FIXED_ONES 8'h48
`define MODE_WMASK 8'hB7

`define CTRL_CLR_A 7
`define CTRL_CKS_HI 6
`define CTRL_CKS_LO 4
`define CKS_DIV1 3'h0
`define CKS_DIV2 3'h1
`define CKS_DIV4 3'h2
`define CKS_DIV8 3'h3

`define REG_RESET 8'h00
`define GR_RESET 16'hFFFF

`endif

// ==== timer_mode_chk.sv ====
// Port assertions for the timer mode and control block.
// Assumes the bench keeps to the APB transfer order.
`include "timer_map.vh"
`default_nettype none
module timer_mode_chk (
    // APB
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic pready,
    // Pins
    input wire logic [3:0] timer_pin_out,
    input wire logic [3:0] compare_match
);
    timeunit 1ns;
    timeprecision 1ps;
    logic rd, wr_m, wr_c, mode_wr_r, ctrl_wr_r, run_r, hit_r;
    logic [3:0] lvl_r;
    assign rd = psel && penable && pready && !pwrite;
    assign wr_m = psel && penable && pready && pwrite && paddr == `OFS_MODE;
    assign wr_c = psel && penable && pready && pwrite && paddr == `OFS_CTRL;
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            mode_wr_r <= 1'b0;
            ctrl_wr_r <= 1'b0;
            run_r <= 1'b0;
            hit_r <= 1'b0;
            lvl_r <= 4'h0;
        end else begin
            hit_r <= wr_c;
            if (wr_m) begin
                mode_wr_r <= 1'b1;
                run_r <= pwdata[`MODE_RUN];
            end
            if (wr_c) begin
                ctrl_wr_r <= 1'b1;
                lvl_r <= pwdata[3:0];
            end
        end
    end
    default clocking cb @(posedge pclk);
    endclocking
    default disable iff (!presetn);
    sequence s_gr_setup;
        psel && !penable && !pwrite && paddr >= `OFS_GRA &&
            paddr <= `OFS_GRD;
    endsequence
    sequence s_gr_wait;
        penable && !pready ##1 pready;
    endsequence
    property p_gr_wait;
        s_gr_setup |=> s_gr_wait;
    endproperty
    property p_mode_rst;
        rd && paddr == `OFS_MODE && !mode_wr_r |-> prdata[7:0] == 8'h48;
    endproperty
    property p_ctrl_rst;
        rd && paddr == `OFS_CTRL && !ctrl_wr_r |-> prdata[7:0] == 8'h00;
    endproperty
    property p_rsv;
        rd && paddr == `OFS_MODE |-> prdata[6] && prdata[3];
    endproperty
    property p_wide;
        rd && paddr >= `OFS_COUNT && paddr <= `OFS_GRD |-> !(|prdata[31:16]);
    endproperty
    property p_init_lvl;
        wr_c |=> timer_pin_out == lvl_r;
    endproperty
    property p_pin_a;
        $changed(timer_pin_out[0]) |-> $past(compare_match[0]) || hit_r;
    endproperty
    property p_run_hold;
        !run_r && !wr_m && !(psel && penable && pwrite) |=>
            $stable(compare_match);
    endproperty
    a_gr_wait: assert property (p_gr_wait)
        else $error("wait state missing");
    a_mode_rst: assert property (p_mode_rst)
        else $error("mode reset value wrong");
    a_ctrl_rst: assert property (p_ctrl_rst)
        else $error("control reset value wrong");
    a_rsv: assert property (p_rsv)
        else $error("reserved bits not one");
    a_wide: assert property (p_wide)
        else $error("upper bits set");
    a_init_lvl: assert property (p_init_lvl)
        else $error("pin level not applied");
    a_pin_a: assert property (p_pin_a)
        else $error("pin A changed without cause");
    a_run_hold: assert property (p_run_hold)
        else $error("counter moved while halted");
endmodule
bind timer_mode_ctrl timer_mode_chk chk (.pclk, .presetn, .psel, .penable,
    .pwrite, .paddr, .pwdata, .prdata, .pready, .timer_pin_out,
    .compare_match);
`default_nettype wire

// ==== timer_mode_ctrl.v ====
// Mode and control part of a 16-bit compare/capture timer, APB slave.
// Assumes pins arrive asynchronously; subclock tick comes from elsewhere.
// Functional notes
// - Counter and four general registers are 16-bit
// - Run bit 7 halts or allows counting
// - Mode bit 5 buffers B through D
// - Mode bit 4 buffers A through C
// - Mode bit 2 selects PWM on pin D
// - Mode bit 1 selects PWM on pin C
// - Mode bit 0 selects PWM on pin B
// - Mode bits 6 and 3 read one
// - Control bit 7 clears counter on match A
// - Clock select 0xx divides system clock
// - Clock select 1xx counts external rising edges
// - Undivided clock counts subclock in low power
// - Control bit 3 sets pin D initial level
// - Control bit 2 sets pin C initial level
// - Control bit 1 sets pin B initial level
// - Control bit 0 sets pin A initial level
// - Initial level writes show on pin immediately
// - Pin A never carries PWM
// - Pins B to D compare, capture or PWM
//
// Local design decisions: the placing of the registers and the APB register port.
`include "timer_map.vh"
`default_nettype none

module timer_mode_ctrl (
    // APB
    input wire pclk,
    input wire presetn,
    input wire psel,
    input wire penable,
    input wire pwrite,
    input wire [7:0] paddr,
    input wire [31:0] pwdata,
    output reg [31:0] prdata,
    output wire pready,
    output wire pslverr,
    // Count sources
    input wire external_event_in,
    input wire subclock_tick,
    // Timer pins, enable low while driving
    input wire [3:0] timer_pin_in,
    output wire [3:0] timer_pin_out,
    output wire [3:0] timer_pin_oe_n,
    // Compare match levels, high while the count equals the general register; low for capture pins and for C or D while buffering
    output wire [3:0] compare_match
);

    reg [7:0] mode_r;
    reg [7:0] ctrl_r;
    reg [3:0] iosel_r;
    reg lowpwr_r;
    reg [15:0] timer_count_r;
    reg [15:0] timer_count_nxt;
    reg [3:0] pin_lvl_r;
    reg [2:0] div_r;
    reg [2:0] ext_sync_r;
    reg [2:0] sub_sync_r;
    reg ext_prev_r;
    reg sub_prev_r;
    reg [11:0] pin_sync_r;
    reg [3:0] pin_prev_r;
    reg rd_pend_r;
    reg [31:0] rdata_nxt;

    wire buffer_pair_b_enable = mode_r[`MODE_BUF_B];
    wire buffer_pair_a_enable = mode_r[`MODE_BUF_A];
    wire [3:0] pwm_sel = {mode_r[`MODE_PWM_D], mode_r[`MODE_PWM_C],
                          mode_r[`MODE_PWM_B], 1'b0};
    wire clear_on_match_a = ctrl_r[`CTRL_CLR_A];
    wire [2:0] cks = ctrl_r[`CTRL_CKS_HI:`CTRL_CKS_LO];

    // APB decode: writes and other reads one-cycle, general register reads wait a cycle for bank data
    wire acc = psel && penable;
    wire wr = acc && pwrite;
    wire rd_gr = psel && !pwrite && paddr >= `OFS_GRA &&
                 paddr <= `OFS_GRD;
    assign pready = pwrite || !rd_gr || rd_pend_r;
    assign pslverr = 1'b0;

    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            rd_pend_r <= 1'b0;
        end else begin
            rd_pend_r <= acc && rd_gr && !rd_pend_r;
        end
    end

    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            mode_r <= `REG_RESET;
            ctrl_r <= `REG_RESET;
            iosel_r <= 4'h0;
            lowpwr_r <= 1'b0;
        end else if (wr) begin
            case (paddr)
                `OFS_MODE: mode_r <= pwdata[7:0] & `MODE_WMASK;
                `OFS_CTRL: ctrl_r <= pwdata[7:0];
                `OFS_IOSEL: iosel_r <= pwdata[3:0];
                `OFS_LOWPWR: lowpwr_r <= pwdata[0];
                default: ;
            endcase
        end
    end

    // Event input synchroniser, three stages
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ext_sync_r <= 3'h0;
            ext_prev_r <= 1'b0;
        end else begin
            ext_sync_r <= {ext_sync_r[1:0], external_event_in};
            if (ext_sync_r[1] == ext_sync_r[2]) begin
                ext_prev_r <= ext_sync_r[2];
            end
        end
    end

    // Subclock synchroniser; prev level keeps one count per rise
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            sub_sync_r <= 3'h0;
            sub_prev_r <= 1'b0;
        end else begin
            sub_sync_r <= {sub_sync_r[1:0], subclock_tick};
            if (sub_sync_r[1] == sub_sync_r[2]) begin
                sub_prev_r <= sub_sync_r[2];
            end
        end
    end

    // Capture pin synchronisers, three stages per pin
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pin_sync_r <= 12'h000;
            pin_prev_r <= 4'h0;
        end else begin
            pin_sync_r <= {pin_sync_r[7:0], timer_pin_in};
            pin_prev_r <= pin_prev_r ^ ((pin_sync_r[7:4] ^ pin_prev_r) &
                          ~(pin_sync_r[7:4] ^ pin_sync_r[11:8]));
        end
    end

    wire ext_stable = ext_sync_r[1] == ext_sync_r[2];
    wire ext_rise = ext_stable && ext_sync_r[2] && !ext_prev_r;
    wire sub_stable = sub_sync_r[1] == sub_sync_r[2];
    wire sub_rise = sub_stable && sub_sync_r[2] && !sub_prev_r;
    wire [3:0] pin_stable = ~(pin_sync_r[7:4] ^ pin_sync_r[11:8]);
    wire [3:0] pin_rise = pin_stable & pin_sync_r[11:8] & ~pin_prev_r;

    // Free-running prescaler
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            div_r <= 3'h0;
        end else begin
            div_r <= div_r + 3'h1;
        end
    end

    reg tick;
    always @* begin
        case (cks)
            `CKS_DIV1: tick = lowpwr_r ? sub_rise : 1'b1;
            `CKS_DIV2: tick = div_r[0];
            `CKS_DIV4: tick = div_r[1:0] == 2'h3;
            `CKS_DIV8: tick = div_r == 3'h7;
            default: tick = ext_rise;
        endcase
    end
    // subclock in low power handled above via lowpwr_r

    // General registers
    wire [63:0] gr_q;
    wire [15:0] gr_rd;
    wire [15:0] general_reg_a = gr_q[15:0];
    wire [15:0] general_reg_b = gr_q[31:16];
    wire [15:0] general_reg_c = gr_q[47:32];
    wire [15:0] general_reg_d = gr_q[63:48];
    wire [3:0] paired = {buffer_pair_b_enable, buffer_pair_a_enable,
                         2'b00};

    wire [3:0] match;
    genvar k;
    generate
        for (k = 0; k < 4; k = k + 1) begin : g_cmp
            assign match[k] = !iosel_r[k] && !paired[k] &&
                              timer_count_r == gr_q[16*k +: 16];
        end
    endgenerate
    assign compare_match = match;

    // Capture strobes
    wire [3:0] cap = pin_rise & iosel_r & ~paired;
    reg [3:0] ld_en;
    reg [63:0] ld_data;
    always @* begin
        ld_en = cap;
        ld_data = {4{timer_count_r}};
        // compare buffer: match A reloads A from C
        if (buffer_pair_a_enable && !iosel_r[0] && match[0]) begin
            ld_en[0] = 1'b1;
            ld_data[15:0] = general_reg_c;
        end
        // compare buffer: match B reloads B from D
        if (buffer_pair_b_enable && !iosel_r[1] && match[1]) begin
            ld_en[1] = 1'b1;
            ld_data[31:16] = general_reg_d;
        end
        // capture buffer: old A moves down to C
        if (buffer_pair_a_enable && iosel_r[0]) begin
            ld_en[2] = cap[0];
            ld_data[47:32] = general_reg_a;
        end
        // capture buffer: old B moves down to D
        if (buffer_pair_b_enable && iosel_r[1]) begin
            ld_en[3] = cap[1];
            ld_data[63:48] = general_reg_b;
        end
    end

    // Bank index: offset of register A wraps to entry 0
    wire gr_hit = paddr >= `OFS_GRA && paddr <= `OFS_GRD;
    wire [1:0] gr_idx = paddr[3:2] + 2'h1;

    gen_reg_bank u_bank (
        .pclk(pclk),
        .presetn(presetn),
        .wr_en(wr && gr_hit),
        .wr_sel(gr_idx),
        .wr_data(pwdata[15:0]),
        .ld_en(ld_en),
        .ld_data(ld_data),
        .q_all(gr_q),
        .rd_sel(gr_idx),
        .rd_data(gr_rd)
    );

    // Counter
    always @* begin
        timer_count_nxt = timer_count_r;
        if (wr && paddr == `OFS_COUNT) begin
            timer_count_nxt = pwdata[15:0];
        end else if (clear_on_match_a && match[0] &&
                     mode_r[`MODE_RUN] && tick) begin
            timer_count_nxt = 16'h0000;
        // one step per tick while running
        end else if (mode_r[`MODE_RUN] && tick) begin
            timer_count_nxt = timer_count_r + 16'h0001;
        end
    end

    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            timer_count_r <= 16'h0000;
        end else begin
            timer_count_r <= timer_count_nxt;
        end
    end

    // Output levels, one next value per pin
    wire ctrl_wr = wr && paddr == `OFS_CTRL;
    wire [3:0] lvl_nxt;
    genvar p;
    generate
        for (p = 0; p < 4; p = p + 1) begin : g_lvl
            reg bit_nxt;
            always @* begin
                bit_nxt = pin_lvl_r[p];
                if (ctrl_wr) begin
                    bit_nxt = pwdata[p];
                // PWM: set at match A, clear at own
                end else if (pwm_sel[p]) begin
                    if (match[p]) begin
                        bit_nxt = 1'b0;
                    end else if (match[0]) begin
                        bit_nxt = 1'b1;
                    end
                // Normal compare output toggles
                end else if (match[p]) begin
                    bit_nxt = ~pin_lvl_r[p];
                end
            end
            assign lvl_nxt[p] = bit_nxt;
        end
    endgenerate

    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pin_lvl_r <= 4'h0;
        end else begin
            pin_lvl_r <= lvl_nxt;
        end
    end

    // pin A compare or capture only, B to D may be PWM
    assign timer_pin_out = pin_lvl_r;
    assign timer_pin_oe_n = iosel_r & ~pwm_sel;

    // Read mux; reserved bits read one
    always @* begin
        rdata_nxt = 32'h00000000;
        case (paddr)
            `OFS_MODE: rdata_nxt = {24'h000000, mode_r | `MODE_FIXED_ONES};
            `OFS_CTRL: rdata_nxt = {24'h000000, ctrl_r};
            `OFS_COUNT: rdata_nxt = {16'h0000, timer_count_r};
            `OFS_IOSEL: rdata_nxt = {28'h0000000, iosel_r};
            `OFS_LOWPWR: rdata_nxt = {31'h00000000, lowpwr_r};
            default: begin
                if (rd_gr) rdata_nxt = {16'h0000, gr_rd};
            end
        endcase
    end

    always @* begin
        prdata = (acc && !pwrite && pready) ? rdata_nxt : 32'h00000000;
    end

endmodule

`default_nettype wire

// ==== timer_mode_ctrl_tb.sv ====
// Self-checking bench for the timer mode and control block.
// Assumes the pin model and the checker are compiled first.
`include "timer_map.vh"
`default_nettype none
module timer_mode_ctrl_tb;
    timeunit 1ns;
    timeprecision 1ps;
    typedef struct {logic [31:0] e; int tol;} note_t;
    logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
    logic [7:0] paddr = 0;
    logic [31:0] pwdata = 0, v, mode_x = 0;
    wire [31:0] prdata;
    wire pready, ev, sub;
    wire [3:0] pin_in, pin_out, oe_n;
    note_t q[$];
    int fail_count = 0, num_checks = 0;
    always #10 pclk = ~pclk;
    timer_mode_ctrl dut (.pclk(pclk), .presetn(presetn), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(),
        .external_event_in(ev), .subclock_tick(sub), .timer_pin_in(pin_in),
        .timer_pin_out(pin_out), .timer_pin_oe_n(oe_n), .compare_match());
    pin_model far (.external_event_in(ev), .subclock_tick(sub),
        .timer_pin_in(pin_in));
    task stop_test;
        $display("checks %0d mismatches %0d", num_checks, fail_count);
        if (fail_count == 0 && num_checks > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask
    task err(input string m);
        $display("[ERR] %0t %s", $time, m);
        fail_count++;
    endtask
    task apb(input logic w, input logic [7:0] a, input logic [31:0] d,
             input int tol);
        int n;
        n = 0;
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        if (!w) q.push_back('{d, tol});
        @(posedge pclk);
        penable <= 1'b1;
        do begin
            @(posedge pclk);
            n++;
        end while (!pready && n < 50);
        if (n >= 50) begin
            err("no ready");
            stop_test;
        end else begin
            psel <= 1'b0;
            penable <= 1'b0;
            @(posedge pclk);
        end
    endtask
    task cmp_rd(input note_t x);
        logic bad;
        num_checks++;
        if (x.tol == 0) bad = prdata !== x.e;
        else bad = $isunknown(prdata) || prdata + x.tol < x.e
            || prdata > x.e + x.tol;
        if (bad) err("read data wrong");
    endtask
    task cmp_pin(input logic [3:0] e);
        num_checks++;
        if (pin_out !== e) err("pin level wrong");
    endtask
    task cmp_oe(input logic [3:0] e);
        num_checks++;
        if (oe_n !== e) err("pin drive enable wrong");
    endtask
    task run(input logic [31:0] c, input int t, input int n, input bit s);
        apb(1, `OFS_COUNT, 0, 0);
        apb(1, `OFS_CTRL, c, 0);
        apb(1, `OFS_MODE, 32'h80 | mode_x, 0);
        if (n > 0) far.pulse(s, n);
        repeat (t) @(posedge pclk);
        apb(1, `OFS_MODE, 0, 0);
    endtask
    always @(posedge pclk) begin
        if (psel && penable && pready && !pwrite && q.size() > 0)
            cmp_rd(q.pop_front());
    end
    initial begin
        v = $urandom(81);
        repeat (12) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        apb(0, `OFS_MODE, 32'h48, 0);
        apb(0, `OFS_CTRL, 0, 0);
        apb(0, `OFS_COUNT, 0, 0);
        for (int i = 0; i < 4; i++)
            apb(0, `OFS_GRA + 8'(4 * i), 32'hFFFF, 0);
        cmp_pin(4'h0);
        cmp_oe(4'h0);
        $display("reset test done");
        apb(1, `OFS_MODE, 32'h37, 0);
        apb(1, `OFS_IOSEL, 32'hF, 0);
        cmp_oe(4'h1);
        apb(1, `OFS_IOSEL, 0, 0);
        apb(0, `OFS_MODE, 32'h7F, 0);
        apb(1, `OFS_MODE, 0, 0);
        apb(0, `OFS_MODE, 32'h48, 0);
        apb(0, 8'h24, 0, 0);
        $display("mode test done");
        repeat (4) begin
            v = $urandom & 32'h0F;
            apb(1, `OFS_CTRL, v, 0);
            cmp_pin(v[3:0]);
            apb(0, `OFS_CTRL, v, 0);
        end
        $display("level test done");
        for (int k = 0; k < 4; k++) begin
            run(k << 4, 64, 0, 0);
            apb(0, `OFS_COUNT, 67 >> k, 2);
        end
        run(32'h40, 8, 5, 0);
        apb(0, `OFS_COUNT, 5, 0);
        apb(1, `OFS_LOWPWR, 1, 0);
        run(0, 8, 3, 1);
        apb(0, `OFS_COUNT, 3, 0);
        apb(1, `OFS_LOWPWR, 0, 0);
        $display("clock test done");
        apb(1, `OFS_GRA, 9, 0);
        apb(1, `OFS_GRB, 4, 0);
        mode_x = 32'h01;
        run(32'h80, 40, 0, 0);
        apb(0, `OFS_COUNT, 3, 0);
        cmp_pin(4'h2);
        $display("clear test done");
        stop_test;
    end
endmodule
`default_nettype wire
